/* File: common/lbd_regs.svh */
// register indices, reset values and timing constants of the led blink/dim block
`ifndef LBD_REGS_SVH
`define LBD_REGS_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define LBD_IDX_INPUT     3'h0
`define LBD_IDX_PSC0      3'h1
`define LBD_IDX_PWM0      3'h2
`define LBD_IDX_PSC1      3'h3
`define LBD_IDX_PWM1      3'h4
`define LBD_IDX_LS0       3'h5
`define LBD_IDX_LS1       3'h6
`define LBD_IDX_STATUS    3'h7
`define LBD_IDX_LAST      3'h6

// ------------------------------------------------------------
// apb decode and status fields
// ------------------------------------------------------------
`define LBD_APB_AW        12
`define LBD_APB_IDX_LSB   2
`define LBD_APB_IDX_MSB   4
`define LBD_APB_HI_LSB    5
`define LBD_ST_VARIANT    0
`define LBD_ST_BUSY0      1
`define LBD_ST_BUSY1      2

// ------------------------------------------------------------
// serial bus slave
// ------------------------------------------------------------
`define LBD_I2C_ADDR_HI   4'h6
`define LBD_CTRL_AI_BIT   4
`define LBD_BIT_LAST      3'h7

// ------------------------------------------------------------
// reset and variant defaults
// ------------------------------------------------------------
`define LBD_NUM_LED       8
`define LBD_LS_RST        8'h00
`define LBD_PSC_DIM_RST   8'h00
`define LBD_PSC_BLK_RST   8'hFF
`define LBD_PWM_DIM_RST   8'h80
`define LBD_PWM_BLK_RST   8'h7F
`define LBD_INIT_LOAD     2'h2
`define LBD_INIT_DONE     2'h3

// ------------------------------------------------------------
// oscillator timing
// ------------------------------------------------------------
`define LBD_OSC_PERIOD_NS     32
`define LBD_PHASE_STEPS       256
`define LBD_DIM_PERIOD_MIN_NS 6250000
`define LBD_BLK_PERIOD_MIN_NS 25000000
`define LBD_DIM_TICK_CYC  ((`LBD_DIM_PERIOD_MIN_NS) / (`LBD_PHASE_STEPS * `LBD_OSC_PERIOD_NS))
`define LBD_BLK_TICK_CYC  ((`LBD_BLK_PERIOD_MIN_NS) / (`LBD_PHASE_STEPS * `LBD_OSC_PERIOD_NS))
`define LBD_TICK_W        12

`endif

/* File: common/lbd_pkg.sv */
// types shared by the led blink/dim block
package lbd_pkg;

  typedef enum logic [1:0] {
    LBD_LS_OFF    = 2'b00,
    LBD_LS_ON     = 2'b01,
    LBD_LS_BLINK0 = 2'b10,
    LBD_LS_BLINK1 = 2'b11
  } lbd_ls_t;

  typedef enum logic [2:0] {
    LBD_ST_IDLE  = 3'b000,
    LBD_ST_ADDR  = 3'b001,
    LBD_ST_ACK   = 3'b010,
    LBD_ST_RX    = 3'b011,
    LBD_ST_TX    = 3'b100,
    LBD_ST_TXACK = 3'b101
  } lbd_i2c_st_t;

endpackage

/* File: common/lbd_cfg_if.sv */
// configuration and blink level between register side and one blink generator
`timescale 1ns/1ns
interface lbd_cfg_if;
  logic       req_tgl;
  logic       blinker;
  logic [7:0] psc;
  logic [7:0] pwm;
  logic       ack_tgl;
  logic       blink;

  modport main (output req_tgl, output blinker, output psc, output pwm, input ack_tgl, input blink);
  modport gen  (input req_tgl, input blinker, input psc, input pwm, output ack_tgl, output blink);
endinterface

/* File: design/lbd_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ns
module lbd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // meta_q feeds q only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* File: design/lbd_blink.sv */
// one blink generator on the oscillator clock
`timescale 1ns/1ns
`include "lbd_regs.svh"
module lbd_blink import lbd_pkg::*; (
  input  wire logic osc_clk,
  input  wire logic presetn,
  lbd_cfg_if.gen    cfg
);

  localparam logic [`LBD_TICK_W-1:0] DIM_LIM = `LBD_TICK_W'(`LBD_DIM_TICK_CYC - 1);
  localparam logic [`LBD_TICK_W-1:0] BLK_LIM = `LBD_TICK_W'(`LBD_BLK_TICK_CYC - 1);

  logic                   orst_n;
  logic                   req_s;
  logic                   ack_q;
  logic                   blk_q;
  logic [7:0]             psc_q;
  logic [7:0]             pwm_q;
  logic [`LBD_TICK_W-1:0] tick_q;
  logic [7:0]             pcnt_q;
  logic [7:0]             phase_q;
  logic                   blink_q;

  // ------------------------------------------------------------
  // reset and handshake crossing
  // ------------------------------------------------------------
  lbd_sync #(.WIDTH(1)) u_rst (.clk(osc_clk), .rst_n(presetn), .d(1'b1), .q(orst_n));
  lbd_sync #(.WIDTH(1)) u_req (.clk(osc_clk), .rst_n(orst_n), .d(cfg.req_tgl), .q(req_s));

  // words are held by the sender until the ack toggles back
  always_ff @(posedge osc_clk or negedge orst_n) begin
    if (!orst_n) begin
      ack_q <= 1'b0;
      blk_q <= 1'b0;
      psc_q <= 8'h00;
      pwm_q <= 8'h00;
    end else if (req_s != ack_q) begin
      ack_q <= req_s;
      blk_q <= cfg.blinker;
      psc_q <= cfg.psc;
      pwm_q <= cfg.pwm;
    end
  end

  // ------------------------------------------------------------
  // period: base tick, 8-bit prescaler, 256 phase steps
  // ------------------------------------------------------------
  always_ff @(posedge osc_clk or negedge orst_n) begin
    if (!orst_n) begin
      tick_q <= '0;
    end else if (tick_q == '0) begin
      tick_q <= blk_q ? BLK_LIM : DIM_LIM;
    end else begin
      tick_q <= tick_q - 1'b1;
    end
  end

  always_ff @(posedge osc_clk or negedge orst_n) begin
    if (!orst_n) begin
      pcnt_q  <= 8'h00;
      phase_q <= 8'h00;
    end else if (tick_q == '0) begin
      if (pcnt_q == 8'h00) begin
        pcnt_q  <= psc_q;
        phase_q <= phase_q + 8'h01;
      end else begin
        pcnt_q <= pcnt_q - 8'h01;
      end
    end
  end

  // blinker reaches always-on, dimmer reaches always-off
  always_ff @(posedge osc_clk or negedge orst_n) begin
    if (!orst_n) begin
      blink_q <= 1'b0;
    end else if (blk_q) begin
      blink_q <= (phase_q <= pwm_q);
    end else begin
      blink_q <= (phase_q < pwm_q);
    end
  end

  assign cfg.ack_tgl = ack_q;
  assign cfg.blink   = blink_q;

endmodule

/* File: design/lbd_top.sv */
// led blink/dim controller: apb and serial-bus register slave, open-drain led bank
`timescale 1ns/1ns
`include "lbd_regs.svh"
module lbd_top import lbd_pkg::*; (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   osc_clk,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`LBD_APB_AW-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   scl_i,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe,
  input  wire logic                   addr_sel_pin_0,
  input  wire logic                   addr_sel_pin_1,
  input  wire logic                   addr_sel_pin_2,
  input  wire logic                   variant_blinker,
  input  wire logic [7:0]             led_i,
  output logic      [7:0]             led_o,
  output logic      [7:0]             led_oe
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic        scl_s;
  logic        sda_s;
  logic [2:0]  pins_s;
  logic        var_s;
  logic [7:0]  led_s;
  logic        scl_d_q;
  logic        sda_d_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic [1:0]  init_cnt_q;
  logic        init_load;
  logic        variant_q;
  logic [7:0]  reg_q [1:6];
  lbd_i2c_st_t st_q;
  logic [2:0]  bit_cnt_q;
  logic [7:0]  shreg_q;
  logic        rw_q;
  logic        first_q;
  logic        ai_q;
  logic [2:0]  idx_q;
  logic        done_q;
  logic        sda_oe_q;
  logic [6:0]  slave_addr;
  logic [7:0]  rx_byte;
  logic [7:0]  i2c_rd;
  logic [2:0]  idx_next;
  logic        i2c_we;
  logic [2:0]  apb_idx;
  logic        apb_hit;
  logic        apb_we;
  logic [7:0]  apb_rd;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [1:0]  blink_v;
  logic [1:0]  busy_v;
  logic [15:0] ls_word;
  logic [7:0]  led_oe_d;
  logic [7:0]  led_oe_q;
  logic [7:0]  led_o_q;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  lbd_sync #(.WIDTH(14)) u_pins (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({scl_i, sda_i, addr_sel_pin_2, addr_sel_pin_1, addr_sel_pin_0, variant_blinker, led_i}),
    .q     ({scl_s, sda_s, pins_s, var_s, led_s})
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d_q <= 1'b0;
      sda_d_q <= 1'b0;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_q;
  assign scl_fall = ~scl_s & scl_d_q;
  assign start_c  = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign stop_c   = scl_s & scl_d_q & ~sda_d_q & sda_s;

  // ------------------------------------------------------------
  // variant strap, caught after reset release
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt_q <= 2'h0;
    end else if (init_cnt_q != `LBD_INIT_DONE) begin
      init_cnt_q <= init_cnt_q + 2'h1;
    end
  end

  assign init_load = (init_cnt_q == `LBD_INIT_LOAD);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      variant_q <= 1'b0;
    end else if (init_load) begin
      variant_q <= var_s;
    end
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  function automatic logic [7:0] rd_byte(input logic [2:0] i);
    rd_byte = (i == `LBD_IDX_INPUT) ? led_s : reg_q[i];
  endfunction

  // serial-bus write wins over apb on the same register in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_q[`LBD_IDX_PSC0] <= `LBD_PSC_DIM_RST;
      reg_q[`LBD_IDX_PWM0] <= `LBD_PWM_DIM_RST;
      reg_q[`LBD_IDX_PSC1] <= `LBD_PSC_DIM_RST;
      reg_q[`LBD_IDX_PWM1] <= `LBD_PWM_DIM_RST;
      reg_q[`LBD_IDX_LS0]  <= `LBD_LS_RST;
      reg_q[`LBD_IDX_LS1]  <= `LBD_LS_RST;
    end else begin
      if (init_load) begin
        reg_q[`LBD_IDX_PSC0] <= var_s ? `LBD_PSC_BLK_RST : `LBD_PSC_DIM_RST;
        reg_q[`LBD_IDX_PSC1] <= var_s ? `LBD_PSC_BLK_RST : `LBD_PSC_DIM_RST;
        reg_q[`LBD_IDX_PWM0] <= var_s ? `LBD_PWM_BLK_RST : `LBD_PWM_DIM_RST;
        reg_q[`LBD_IDX_PWM1] <= var_s ? `LBD_PWM_BLK_RST : `LBD_PWM_DIM_RST;
      end
      for (int k = 1; k <= 6; k++) begin
        if (i2c_we && idx_q == 3'(k)) begin
          reg_q[k] <= rx_byte;
        end else if (apb_we && apb_idx == 3'(k)) begin
          reg_q[k] <= pwdata[7:0];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // serial-bus slave
  // ------------------------------------------------------------
  assign slave_addr = {`LBD_I2C_ADDR_HI, pins_s};
  assign rx_byte    = {shreg_q[6:0], sda_s};
  assign i2c_rd     = rd_byte(idx_q);
  assign idx_next   = (idx_q == `LBD_IDX_LAST) ? `LBD_IDX_INPUT : idx_q + 3'h1;
  assign i2c_we     = (st_q == LBD_ST_RX) && scl_rise && (bit_cnt_q == `LBD_BIT_LAST) && !first_q
                      && (idx_q != `LBD_IDX_INPUT) && (idx_q <= `LBD_IDX_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= LBD_ST_IDLE;
      bit_cnt_q <= 3'h0;
      shreg_q   <= 8'h00;
      rw_q      <= 1'b0;
      first_q   <= 1'b0;
      ai_q      <= 1'b0;
      idx_q     <= 3'h0;
      done_q    <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else if (start_c) begin
      st_q      <= LBD_ST_ADDR;
      bit_cnt_q <= 3'h0;
      done_q    <= 1'b0;
      first_q   <= 1'b1;
      sda_oe_q  <= 1'b0;
    end else if (stop_c) begin
      st_q     <= LBD_ST_IDLE;
      done_q   <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (st_q)
        LBD_ST_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        LBD_ST_ADDR: begin
          if (scl_rise) begin
            shreg_q   <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == `LBD_BIT_LAST) begin
              done_q <= 1'b1;
              rw_q   <= sda_s;
            end
          end else if (scl_fall && done_q) begin
            done_q    <= 1'b0;
            bit_cnt_q <= 3'h0;
            if (shreg_q[7:1] == slave_addr) begin
              st_q     <= LBD_ST_ACK;
              sda_oe_q <= 1'b1;
            end else begin
              st_q <= LBD_ST_IDLE;
            end
          end
        end
        LBD_ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 3'h0;
            if (rw_q) begin
              shreg_q  <= i2c_rd;
              sda_oe_q <= ~i2c_rd[7];
              st_q     <= LBD_ST_TX;
            end else begin
              sda_oe_q <= 1'b0;
              st_q     <= LBD_ST_RX;
            end
          end
        end
        LBD_ST_RX: begin
          if (scl_rise) begin
            shreg_q   <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == `LBD_BIT_LAST) begin
              done_q <= 1'b1;
              if (first_q) begin
                first_q <= 1'b0;
                ai_q    <= rx_byte[`LBD_CTRL_AI_BIT];
                // out-of-range index falls back to the input register
                idx_q   <= (rx_byte[2:0] > `LBD_IDX_LAST) ? `LBD_IDX_INPUT : rx_byte[2:0];
              end else if (ai_q) begin
                idx_q <= idx_next;
              end
            end
          end else if (scl_fall && done_q) begin
            done_q    <= 1'b0;
            bit_cnt_q <= 3'h0;
            st_q      <= LBD_ST_ACK;
            sda_oe_q  <= 1'b1;
          end
        end
        LBD_ST_TX: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == `LBD_BIT_LAST) begin
              done_q <= 1'b1;
              if (ai_q) begin
                idx_q <= idx_next;
              end
            end
          end else if (scl_fall) begin
            if (done_q) begin
              done_q   <= 1'b0;
              sda_oe_q <= 1'b0;
              st_q     <= LBD_ST_TXACK;
            end else begin
              shreg_q  <= {shreg_q[6:0], 1'b0};
              sda_oe_q <= ~shreg_q[6];
            end
          end
        end
        LBD_ST_TXACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              st_q <= LBD_ST_IDLE;
            end else begin
              done_q <= 1'b1;
            end
          end else if (scl_fall && done_q) begin
            done_q    <= 1'b0;
            bit_cnt_q <= 3'h0;
            shreg_q   <= i2c_rd;
            sda_oe_q  <= ~i2c_rd[7];
            st_q      <= LBD_ST_TX;
          end
        end
        default: begin
          st_q     <= LBD_ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // apb slave, one wait state
  // ------------------------------------------------------------
  assign apb_idx = paddr[`LBD_APB_IDX_MSB:`LBD_APB_IDX_LSB];
  assign apb_hit = (paddr[`LBD_APB_AW-1:`LBD_APB_HI_LSB] == '0) && (paddr[1:0] == 2'h0);
  assign apb_we  = psel && penable && pwrite && pready_q && apb_hit;
  assign apb_rd  = (apb_idx == `LBD_IDX_STATUS) ? {5'h00, busy_v, variant_q} : rd_byte(apb_idx);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (psel && penable && !pready_q) begin
      pready_q  <= 1'b1;
      pslverr_q <= ~apb_hit;
      prdata_q  <= apb_hit ? {24'h00_0000, apb_rd} : 32'h0000_0000;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // blink generators and configuration handshake
  // ------------------------------------------------------------
  lbd_cfg_if u_cfg [2] ();

  for (genvar g = 0; g < 2; g++) begin : g_gen
    logic        req_q;
    logic        ack_s;
    logic        blink_s;
    logic [16:0] sent_q;
    logic [16:0] cfg_word;

    assign cfg_word = {variant_q, reg_q[3'(`LBD_IDX_PSC0 + 2 * g)], reg_q[3'(`LBD_IDX_PWM0 + 2 * g)]};
    assign busy_v[g] = req_q ^ ack_s;

    // only one word in flight; later edits are resent once the ack returns
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        req_q  <= 1'b0;
        sent_q <= 17'h0_0000;
      end else if (!busy_v[g] && cfg_word != sent_q) begin
        req_q  <= ~req_q;
        sent_q <= cfg_word;
      end
    end

    assign u_cfg[g].req_tgl = req_q;
    assign u_cfg[g].blinker = sent_q[16];
    assign u_cfg[g].psc     = sent_q[15:8];
    assign u_cfg[g].pwm     = sent_q[7:0];

    lbd_blink u_blink (
      .osc_clk (osc_clk),
      .presetn (presetn),
      .cfg     (u_cfg[g])
    );

    lbd_sync #(.WIDTH(2)) u_back (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({u_cfg[g].ack_tgl, u_cfg[g].blink}),
      .q     ({ack_s, blink_s})
    );

    assign blink_v[g] = blink_s;
  end

  // ------------------------------------------------------------
  // open-drain led drivers
  // ------------------------------------------------------------
  assign ls_word = {reg_q[`LBD_IDX_LS1], reg_q[`LBD_IDX_LS0]};

  always_comb begin
    lbd_ls_t ls_v;
    ls_v     = LBD_LS_OFF;
    led_oe_d = 8'h00;
    for (int i = 0; i < `LBD_NUM_LED; i++) begin
      ls_v = lbd_ls_t'(ls_word[2*i +: 2]);
      unique case (ls_v)
        LBD_LS_OFF:    led_oe_d[i] = 1'b0;
        LBD_LS_ON:     led_oe_d[i] = 1'b1;
        LBD_LS_BLINK0: led_oe_d[i] = blink_v[0];
        LBD_LS_BLINK1: led_oe_d[i] = blink_v[1];
      endcase
    end
  end

  // the pins only ever sink; a pull-up makes the high level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_oe_q <= 8'h00;
      led_o_q  <= 8'h00;
    end else begin
      led_oe_q <= led_oe_d;
      led_o_q  <= 8'h00;
    end
  end

  assign led_oe  = led_oe_q;
  assign led_o   = led_o_q;
  assign sda_oe  = sda_oe_q;
  assign sda_o   = 1'b0;
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

endmodule

/* File: verification/lbd_asserts.sv */
// port assertions for the led blink/dim controller
`timescale 1ns/1ns
`include "lbd_regs.svh"
module lbd_asserts (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`LBD_APB_AW-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   sda_o,
  input wire logic [7:0]             led_o,
  input wire logic [7:0]             led_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  sequence ls0_wr_s;
    psel && penable && pready && pwrite && paddr == 12'h014;
  endsequence
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  ready_wait_a: assert property (acc_s |=> pready) else $error("no answer after one wait");
  err_unmapped_a: assert property (acc_s ##0 paddr[11:5] != 7'h00 |=> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
  err_mapped_a: assert property (acc_s ##0 paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  rdata_hold_a: assert property ($changed(prdata) |-> pready) else $error("prdata moved");
  drive_low_a: assert property (led_o == 8'h00 && sda_o == 1'b0) else $error("pin driven high");
  reset_off_a: assert property ($rose(presetn) |-> led_oe == 8'h00) else $error("led on at reset");
  ls_on_a: assert property (ls0_wr_s ##0 pwdata[7:0] == 8'h55 |-> ##[1:4] led_oe[3:0] == 4'hF)
    else $error("led not sinking");
  ls_off_a: assert property (ls0_wr_s ##0 pwdata[7:0] == 8'h00 |-> ##[1:4] led_oe[3:0] == 4'h0)
    else $error("led not released");
endmodule

/* File: verification/lbd_i2c_master.sv */
// serial-bus master model facing the block's slave port
`timescale 1ns/1ns
module lbd_i2c_master (
  input wire logic pclk,
  input wire logic sda_in,
  output logic     scl = 1'b1,
  output logic     sda_oe = 1'b0
);
  // slow phases: the slave sees both lines through two pclk flops
  task automatic hc();
    repeat (20) @(posedge pclk);
  endtask
  task automatic start();
    sda_oe <= 1'b1;
    hc();
    scl <= 1'b0;
    hc();
  endtask
  task automatic stop();
    sda_oe <= 1'b1;
    hc();
    scl <= 1'b1;
    hc();
    sda_oe <= 1'b0;
    hc();
  endtask
  // eight bits msb first then the ack slot; a 1 releases the line
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_oe <= !tx[i];
      hc();
      scl <= 1'b1;
      hc();
      rx[i] = sda_in;
      scl <= 1'b0;
      hc();
    end
  endtask
endmodule

/* File: verification/testbench.sv */
// self-checking bench for the led blink/dim controller
`timescale 1ns/1ns
module testbench;
  logic        pclk, presetn, osc_clk, psel, penable, pwrite, variant;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, sda_o, sda_oe, scl, m_oe;
  logic [7:0]  led_o, led_oe;
  wire         sda = !(sda_oe | m_oe);
  wire  [7:0]  led_pin = ~led_oe;
  int          n_fail = 0;
  int          checks = 0;
  lbd_top DUT (.pclk(pclk), .presetn(presetn), .osc_clk(osc_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel_pin_0(1'b1), .addr_sel_pin_1(1'b0),
    .addr_sel_pin_2(1'b1), .variant_blinker(variant), .led_i(led_pin), .led_o(led_o), .led_oe(led_oe));
  lbd_i2c_master u_bus (.pclk(pclk), .sda_in(sda), .scl(scl), .sda_oe(m_oe));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    osc_clk = 1'b0;
    #7;
    forever #16 osc_clk = ~osc_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge, so a following call never drives psel twice in one step
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0, d, e);
    chk(d, exp, "read data");
    chk({31'h0, e}, {31'h0, eexp}, "error flag");
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, a, {24'h0, v}, d, e);
  endtask
  task automatic sx(input logic [8:0] tx, input logic [8:0] exp, input logic [8:0] m);
    logic [8:0] r;
    u_bus.xfer(tx, r);
    chk({23'h0, r & m}, {23'h0, exp & m}, "serial byte");
  endtask
  task automatic t_defaults(input logic blk);
    presetn <= 1'b0;
    variant <= blk;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    for (int i = 1; i <= 3; i += 2) begin
      rdc(12'(i * 4), blk ? 32'hFF : 32'h00, 1'b0);
      rdc(12'(i * 4 + 4), blk ? 32'h7F : 32'h80, 1'b0);
    end
    rdc(12'h014, 32'h0, 1'b0);
    rdc(12'h018, 32'h0, 1'b0);
    rdc(12'h01C, {31'h0, blk}, 1'b0);
    chk({24'h0, led_oe}, 32'h0, "outputs after reset");
    $display("test defaults done");
  endtask
  task automatic t_outputs();
    wr(12'h014, 8'h55);
    wr(12'h018, 8'h41);
    repeat (8) @(posedge pclk);
    chk({24'h0, led_oe}, 32'h9F, "outputs on");
    rdc(12'h000, 32'h60, 1'b0);
    wr(12'h014, 8'h00);
    rdc(12'h020, 32'h0, 1'b1);
    rdc(12'h016, 32'h0, 1'b1);
    $display("test outputs done");
  endtask
  task automatic t_serial();
    u_bus.start();
    sx(9'h0D5, 9'h000, 9'h001);
    sx(9'h027, 9'h000, 9'h001);
    sx(9'h043, 9'h000, 9'h001);
    sx(9'h085, 9'h000, 9'h001);
    u_bus.stop();
    rdc(12'h00C, 32'h21, 1'b0);
    rdc(12'h010, 32'h42, 1'b0);
    u_bus.start();
    sx(9'h0C5, 9'h001, 9'h001);
    u_bus.stop();
    u_bus.start();
    sx(9'h0D5, 9'h000, 9'h001);
    sx(9'h02D, 9'h000, 9'h001);
    u_bus.stop();
    u_bus.start();
    sx(9'h0D7, 9'h000, 9'h001);
    sx(9'h1FE, {8'h41, 1'b0}, 9'h1FE);
    sx(9'h1FF, {8'h6F, 1'b0}, 9'h1FE);
    u_bus.stop();
    $display("test serial done");
  endtask
  task automatic t_duty(input logic blk);
    int bad;
    bad = 0;
    t_defaults(blk);
    wr(12'h004, 8'h00);
    wr(12'h008, blk ? 8'hFF : 8'h00);
    wr(12'h014, 8'h02);
    // generator config crosses to the oscillator domain first
    repeat (200) @(posedge pclk);
    repeat (2000) begin
      @(posedge pclk);
      if (led_oe[0] !== blk) bad++;
    end
    chk(bad, 0, "duty extreme");
    $display("test duty done");
  endtask
  initial begin
    presetn = 1'b0;
    variant = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    @(posedge pclk);
    t_defaults(1'b0);
    t_outputs();
    t_serial();
    t_duty(1'b0);
    t_duty(1'b1);
    report_and_stop();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    report_and_stop();
  end
endmodule
bind lbd_top lbd_asserts u_chk (.*);
